/* File: logic/dcp_pkg.sv */
// Constants, field layouts and carrier types for the configuration and key register bank.
// Assumes a 125 MHz core clock and a byte-wide, word-addressed register port.
package dcp_pkg;

  // Word addresses
  localparam logic [5:0] ADDR_WAKE_TRANS = 6'h00;
  localparam logic [5:0] ADDR_RST_REL    = 6'h01;
  localparam logic [5:0] ADDR_SUPPLY     = 6'h02;
  localparam logic [5:0] ADDR_KEY        = 6'h03;
  localparam logic [5:0] ADDR_PROT_FIRST = 6'h04;
  localparam logic [5:0] ADDR_PROT_LAST  = 6'h0A;
  localparam logic [5:0] ADDR_STAT_FIRST = 6'h0B;
  localparam logic [5:0] ADDR_STAT_LAST  = 6'h11;
  localparam logic [5:0] ADDR_PROT_STAT  = 6'h28;
  localparam int         NUM_PROT        = 7;

  // Field positions
  localparam int BIT_WAKE_ON    = 7;
  localparam int BIT_WAKE_TICK  = 6;
  localparam int BIT_LP_DEL_HI  = 3;
  localparam int BIT_RST_HI     = 2;
  localparam int BIT_EXT_CORE   = 7;
  localparam int BIT_BOOST      = 6;
  localparam int BIT_BUCK_FREQ  = 5;
  localparam int BIT_LOAD_WATCH = 4;
  localparam int BIT_LIMIT_HI   = 3;
  localparam int BIT_LIMIT_LO   = 2;
  localparam int BIT_SYNC_PHASE = 1;
  localparam int BIT_SYNC_ON    = 0;

  // Reset values
  localparam logic [7:0] RST_WAKE_TRANS = 8'h08;
  localparam logic [2:0] RST_RST_REL    = 3'h6;
  localparam logic [4:0] RST_SUPPLY_RW  = 5'h00;
  localparam logic [7:0] RST_KEY        = 8'h00;
  localparam logic [NUM_PROT-1:0][7:0] RST_PROT =
    {8'h0B, 8'h06, 8'h0B, 8'h09, 8'h9B, 8'h08, 8'h01};

  // Key sequences, first byte in entry 0
  localparam logic [3:0][7:0] KEY_UNLOCK = {8'h12, 8'h56, 8'hEF, 8'hAB};
  localparam logic [3:0][7:0] KEY_LOCK   = {8'hCA, 8'hBE, 8'h34, 8'hDF};

  // Times in microseconds; cycles derive from the clock rate
  localparam int unsigned CLK_MHZ       = 125;
  localparam int unsigned WAKE_FAST_US  = 10;
  localparam int unsigned WAKE_SLOW_US  = 10000;
  localparam int unsigned LP_STEP_US    = 100;
  localparam int unsigned RST_DEL_US [8] =
    '{200, 400, 800, 1000, 2000, 4000, 10000, 15000};

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } dcp_req_t;

  typedef struct packed {
    logic [NUM_PROT-1:0][7:0] val;
  } dcp_cfg_t;

  typedef enum logic [1:0] {TMR_IDLE, TMR_WAIT, TMR_DONE} dcp_tmr_t;

endpackage

/* File: logic/dcp_key_seq.sv */
// Four-byte unlock and lock key matcher for the protection key register.
// Assumes key_wr pulses once per byte written to the key address.
`timescale 1ns/1ps
module dcp_key_seq (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       ce,
  input  wire logic       key_wr,
  input  wire logic [7:0] key_byte,
  output logic            unlock_hit,
  output logic            lock_hit
);

  logic [1:0] unl_idx_reg;
  logic [1:0] unl_idx_next;
  logic [1:0] lck_idx_reg;
  logic [1:0] lck_idx_next;

  // A wrong byte restarts matching; it may itself be a fresh first byte
  function automatic logic [1:0] advance(input logic [1:0] idx,
                                         input logic [7:0] b,
                                         input logic [3:0][7:0] seq);
    logic [1:0] r;
    r = 2'h0;
    if (b == seq[idx]) begin
      r = idx + 2'h1; // [RL12] [RL13]
    end else if (b == seq[0]) begin
      r = 2'h1; // [RL17]
    end
    return r;
  endfunction

  always_comb begin
    unl_idx_next = unl_idx_reg;
    lck_idx_next = lck_idx_reg;
    unlock_hit   = 1'b0;
    lock_hit     = 1'b0;
    if (key_wr) begin
      unl_idx_next = advance(unl_idx_reg, key_byte, dcp_pkg::KEY_UNLOCK);
      lck_idx_next = advance(lck_idx_reg, key_byte, dcp_pkg::KEY_LOCK);
      unlock_hit   = (unl_idx_reg == 2'h3) && (key_byte == dcp_pkg::KEY_UNLOCK[3]); // [RL12]
      lock_hit     = (lck_idx_reg == 2'h3) && (key_byte == dcp_pkg::KEY_LOCK[3]);   // [RL13]
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      unl_idx_reg <= 2'h0;
      lck_idx_reg <= 2'h0;
    end else if (ce) begin
      unl_idx_reg <= unl_idx_next;
      lck_idx_reg <= lck_idx_next;
    end
  end

endmodule // dcp_key_seq

/* File: logic/dcp_regbank.sv */
// Device configuration registers, protection key and protected request bank.
// Assumes a serial front end that turns frames into one-cycle read/write requests.
//
// Function
// RL1: The wake timer runs in sleep or standby only while its enable bit 7 is set.
// RL2: The wake tick select bit picks a 10 us tick when clear and 10 ms when set.
// RL3: The four-bit entry delay gives (code+1) x 100 us before standby or sleep, reset code 8.
// RL4: The three-bit reset release code picks 200 us to 15 ms, reset code 6.
// RL5: Bit 7 of the supply register reads the external core supply status.
// RL6: Bit 6 of the supply register reads the boost converter status.
// RL7: Bit 5 of the supply register reads the buck frequency range.
// RL8: The load current watch bit enables monitoring, forced on in sleep.
// RL9: The two-bit limit field picks 10, 30, 60 or 100 mA.
// RL10: The sync phase bit shifts the sync output by half a period.
// RL11: Bit 0 of the supply register enables the sync output.
// RL12: The unlock key AB EF 56 12 grants write access to the protected registers.
// RL13: The lock key DF 34 BE CA removes write access to the protected registers.
// RL14: Protected values reach the safe-state and watchdog modules only on lock.
// RL15: The host sends each key as four consecutive byte writes; the key register resets to 0.
// RL16: Protected requests sit at 0x04 to 0x0A, applied mirrors from 0x0B.
// RL17: A byte that breaks a key sequence restarts matching from the first byte.
`timescale 1ns/1ps
module dcp_regbank #(
  parameter int unsigned CYC_PER_US = dcp_pkg::CLK_MHZ
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              ce,
  input  wire dcp_pkg::dcp_req_t req,
  output logic [7:0]             rdata,
  output logic                   rvalid,
  input  wire logic              ext_core_supply_in,
  input  wire logic              boost_on_in,
  input  wire logic              buck_freq_in,
  input  wire logic              low_power_state,
  input  wire logic              sleep_state,
  input  wire logic              lp_request,
  output logic                   lp_enter,
  input  wire logic              reset_release_req,
  output logic                   reset_release,
  input  wire logic              sync_src,
  output logic                   sync_out,
  output logic                   wake_tick,
  output logic                   load_watch_active,
  output logic [1:0]             load_current_limit,
  output logic                   prot_unlocked,
  output logic                   apply_pulse,
  output dcp_pkg::dcp_cfg_t      applied_cfg
);

  localparam logic [31:0] WAKE_FAST_CYC = 32'(dcp_pkg::WAKE_FAST_US * CYC_PER_US);
  localparam logic [31:0] WAKE_SLOW_CYC = 32'(dcp_pkg::WAKE_SLOW_US * CYC_PER_US);
  localparam logic [31:0] LP_STEP_CYC   = 32'(dcp_pkg::LP_STEP_US * CYC_PER_US);

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Register state

  logic [7:0]        wake_trans_reg, wake_trans_next;
  logic [2:0]        rst_rel_reg, rst_rel_next;
  logic [4:0]        supply_rw_reg, supply_rw_next;
  logic [2:0]        supply_ro_reg, supply_ro_next;
  logic [7:0]        key_reg, key_next;
  logic              unlocked_reg, unlocked_next;
  dcp_pkg::dcp_cfg_t prot_reg, prot_next;
  dcp_pkg::dcp_cfg_t applied_reg, applied_next;
  logic              apply_reg, apply_next;
  logic [7:0]        rdata_reg, rdata_next;
  logic              rvalid_reg, rvalid_next;
  logic              unlock_hit, lock_hit;
  logic              key_wr;
  logic [5:0]        prot_idx, stat_idx;

  assign key_wr   = req.wr && (req.addr == dcp_pkg::ADDR_KEY);
  assign prot_idx = req.addr - dcp_pkg::ADDR_PROT_FIRST;
  assign stat_idx = req.addr - dcp_pkg::ADDR_STAT_FIRST;

  dcp_key_seq u_key (
    .clk        (clk),
    .reset_n    (reset_n),
    .ce         (ce),
    .key_wr     (key_wr),
    .key_byte   (req.wdata),
    .unlock_hit (unlock_hit),
    .lock_hit   (lock_hit)
  );

  always_comb begin
    wake_trans_next = wake_trans_reg;
    rst_rel_next    = rst_rel_reg;
    supply_rw_next  = supply_rw_reg;
    key_next        = key_reg;
    unlocked_next   = unlocked_reg;
    prot_next       = prot_reg;
    applied_next    = applied_reg;
    apply_next      = 1'b0;
    // Status bits are sampled so they read zero out of reset
    supply_ro_next  = {ext_core_supply_in, boost_on_in, buck_freq_in}; // [RL5] [RL6] [RL7]
    if (req.wr) begin
      unique case (req.addr)
        dcp_pkg::ADDR_WAKE_TRANS: wake_trans_next = {req.wdata[7:6], 2'h0, req.wdata[3:0]};
        dcp_pkg::ADDR_RST_REL:    rst_rel_next    = req.wdata[dcp_pkg::BIT_RST_HI:0];
        dcp_pkg::ADDR_SUPPLY:     supply_rw_next  = req.wdata[dcp_pkg::BIT_LOAD_WATCH:0];
        dcp_pkg::ADDR_KEY:        key_next        = req.wdata; // [RL15]
        default: begin
          // Protected writes are dropped silently while locked
          if (unlocked_reg && req.addr >= dcp_pkg::ADDR_PROT_FIRST &&
              req.addr <= dcp_pkg::ADDR_PROT_LAST) begin
            prot_next.val[prot_idx[2:0]] = req.wdata; // [RL12] [RL16]
          end
        end
      endcase
    end
    if (unlock_hit) begin
      unlocked_next = 1'b1; // [RL12]
    end
    if (lock_hit) begin
      unlocked_next = 1'b0; // [RL13]
      applied_next  = prot_reg; // [RL14]
      apply_next    = 1'b1; // [RL14]
    end
  end

  // Read path, one cycle latency; unmapped words read zero
  always_comb begin
    rdata_next  = rdata_reg;
    rvalid_next = req.rd;
    if (req.rd) begin
      rdata_next = 8'h00;
      if (req.addr == dcp_pkg::ADDR_WAKE_TRANS) begin
        rdata_next = wake_trans_reg;
      end else if (req.addr == dcp_pkg::ADDR_RST_REL) begin
        rdata_next = {5'h00, rst_rel_reg};
      end else if (req.addr == dcp_pkg::ADDR_SUPPLY) begin
        rdata_next = {supply_ro_reg, supply_rw_reg}; // [RL5] [RL6] [RL7]
      end else if (req.addr == dcp_pkg::ADDR_KEY) begin
        rdata_next = key_reg;
      end else if (req.addr >= dcp_pkg::ADDR_PROT_FIRST &&
                   req.addr <= dcp_pkg::ADDR_PROT_LAST) begin
        rdata_next = prot_reg.val[prot_idx[2:0]];
      end else if (req.addr >= dcp_pkg::ADDR_STAT_FIRST &&
                   req.addr <= dcp_pkg::ADDR_STAT_LAST) begin
        rdata_next = applied_reg.val[stat_idx[2:0]]; // [RL16]
      end else if (req.addr == dcp_pkg::ADDR_PROT_STAT) begin
        rdata_next = {7'h00, ~unlocked_reg};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wake_trans_reg <= dcp_pkg::RST_WAKE_TRANS; // [RL1] [RL2] [RL3]
      rst_rel_reg    <= dcp_pkg::RST_RST_REL; // [RL4]
      supply_rw_reg  <= dcp_pkg::RST_SUPPLY_RW;
      supply_ro_reg  <= 3'h0;
      key_reg        <= dcp_pkg::RST_KEY; // [RL15]
      unlocked_reg   <= 1'b0;
      prot_reg       <= dcp_pkg::RST_PROT;
      applied_reg    <= dcp_pkg::RST_PROT;
      apply_reg      <= 1'b0;
      rdata_reg      <= 8'h00;
      rvalid_reg     <= 1'b0;
    end else if (ce) begin
      wake_trans_reg <= wake_trans_next;
      rst_rel_reg    <= rst_rel_next;
      supply_rw_reg  <= supply_rw_next;
      supply_ro_reg  <= supply_ro_next;
      key_reg        <= key_next;
      unlocked_reg   <= unlocked_next;
      prot_reg       <= prot_next;
      applied_reg    <= applied_next;
      apply_reg      <= apply_next;
      rdata_reg      <= rdata_next;
      rvalid_reg     <= rvalid_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Wake timer tick

  logic [31:0] wake_cnt_reg, wake_cnt_next;
  logic        wake_tick_reg, wake_tick_next;
  logic [31:0] wake_period;

  assign wake_period = wake_trans_reg[dcp_pkg::BIT_WAKE_TICK] ? WAKE_SLOW_CYC
                                                               : WAKE_FAST_CYC; // [RL2]

  always_comb begin
    wake_cnt_next  = 32'h0;
    wake_tick_next = 1'b0;
    // Timer stays cleared outside low power so each stay starts a full period
    if (wake_trans_reg[dcp_pkg::BIT_WAKE_ON] && low_power_state) begin // [RL1]
      if (wake_cnt_reg >= wake_period - 32'h1) begin
        wake_tick_next = 1'b1;
      end else begin
        wake_cnt_next = wake_cnt_reg + 32'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wake_cnt_reg  <= 32'h0;
      wake_tick_reg <= 1'b0;
    end else if (ce) begin
      wake_cnt_reg  <= wake_cnt_next;
      wake_tick_reg <= wake_tick_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Low power entry delay and reset release delay

  dcp_pkg::dcp_tmr_t lp_st_reg, lp_st_next, rr_st_reg, rr_st_next;
  logic [31:0]       lp_cnt_reg, lp_cnt_next, rr_cnt_reg, rr_cnt_next;
  logic [31:0]       lp_target, rr_target;

  assign lp_target = 32'((wake_trans_reg[dcp_pkg::BIT_LP_DEL_HI:0] + 5'h01) *
                         LP_STEP_CYC); // [RL3]
  assign rr_target = 32'(dcp_pkg::RST_DEL_US[rst_rel_reg] * CYC_PER_US); // [RL4]

  always_comb begin
    lp_st_next  = lp_st_reg;
    lp_cnt_next = lp_cnt_reg;
    rr_st_next  = rr_st_reg;
    rr_cnt_next = rr_cnt_reg;
    unique case (lp_st_reg)
      dcp_pkg::TMR_IDLE: begin
        lp_cnt_next = 32'h1;
        if (lp_request) begin
          lp_st_next = dcp_pkg::TMR_WAIT;
        end
      end
      dcp_pkg::TMR_WAIT: begin
        lp_cnt_next = lp_cnt_reg + 32'h1;
        if (!lp_request) begin
          lp_st_next = dcp_pkg::TMR_IDLE;
        end else if (lp_cnt_reg >= lp_target) begin
          lp_st_next = dcp_pkg::TMR_DONE; // [RL3]
        end
      end
      dcp_pkg::TMR_DONE: begin
        if (!lp_request) begin
          lp_st_next = dcp_pkg::TMR_IDLE;
        end
      end
      default: lp_st_next = dcp_pkg::TMR_IDLE;
    endcase
    unique case (rr_st_reg)
      dcp_pkg::TMR_IDLE: begin
        rr_cnt_next = 32'h1;
        if (reset_release_req) begin
          rr_st_next = dcp_pkg::TMR_WAIT;
        end
      end
      dcp_pkg::TMR_WAIT: begin
        rr_cnt_next = rr_cnt_reg + 32'h1;
        if (!reset_release_req) begin
          rr_st_next = dcp_pkg::TMR_IDLE;
        end else if (rr_cnt_reg >= rr_target) begin
          rr_st_next = dcp_pkg::TMR_DONE; // [RL4]
        end
      end
      dcp_pkg::TMR_DONE: begin
        if (!reset_release_req) begin
          rr_st_next = dcp_pkg::TMR_IDLE;
        end
      end
      default: rr_st_next = dcp_pkg::TMR_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lp_st_reg  <= dcp_pkg::TMR_IDLE;
      rr_st_reg  <= dcp_pkg::TMR_IDLE;
      lp_cnt_reg <= 32'h1;
      rr_cnt_reg <= 32'h1;
    end else if (ce) begin
      lp_st_reg  <= lp_st_next;
      rr_st_reg  <= rr_st_next;
      lp_cnt_reg <= lp_cnt_next;
      rr_cnt_reg <= rr_cnt_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign rdata              = rdata_reg;
  assign rvalid             = rvalid_reg;
  assign wake_tick          = wake_tick_reg;
  assign lp_enter           = (lp_st_reg == dcp_pkg::TMR_DONE);
  assign reset_release      = (rr_st_reg == dcp_pkg::TMR_DONE);
  assign load_watch_active  = supply_rw_reg[dcp_pkg::BIT_LOAD_WATCH] | sleep_state; // [RL8]
  assign load_current_limit = supply_rw_reg[dcp_pkg::BIT_LIMIT_HI:dcp_pkg::BIT_LIMIT_LO]; // [RL9]
  // Source passes straight through; phase flip is an inversion of the sync reference
  assign sync_out           = supply_rw_reg[dcp_pkg::BIT_SYNC_ON] &
                              (sync_src ^ supply_rw_reg[dcp_pkg::BIT_SYNC_PHASE]); // [RL10] [RL11]
  assign prot_unlocked      = unlocked_reg;
  assign apply_pulse        = apply_reg;
  assign applied_cfg        = applied_reg; // [RL14]

endmodule // dcp_regbank

/* File: tb/dcp_regbank_assertions.sv */
// Checker for the register bank ports: answers, key effects and timer gating.
// Assumes one clock domain and is bound to every dcp_regbank instance.
`timescale 1ns/1ps
module dcp_regbank_checker #(
  parameter int unsigned CYC_PER_US = dcp_pkg::CLK_MHZ
) (
  input wire logic              clk,
  input wire logic              reset_n,
  input wire logic              ce,
  input wire dcp_pkg::dcp_req_t req,
  input wire logic              rvalid,
  input wire logic              sleep_state,
  input wire logic              load_watch_active,
  input wire logic [1:0]        load_current_limit,
  input wire logic              lp_request,
  input wire logic              lp_enter,
  input wire logic              low_power_state,
  input wire logic              wake_tick,
  input wire logic              reset_release_req,
  input wire logic              reset_release,
  input wire logic              prot_unlocked,
  input wire logic              apply_pulse,
  input wire dcp_pkg::dcp_cfg_t applied_cfg
);
  // Shortest legal waits; a mid-run reset must last two cycles for $stable
  localparam int LP_MIN  = 100 * CYC_PER_US;
  localparam int REL_MIN = 200 * CYC_PER_US;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////
  a_rd_answer: assert property (ce && req.rd |=> rvalid)
    else $error("read got no answer");
  a_watch_forced: assert property (sleep_state |-> load_watch_active)
    else $error("load watch not forced in sleep");
  a_limit_write: assert property (ce && req.wr && req.addr == dcp_pkg::ADDR_SUPPLY
    |=> load_current_limit == $past(req.wdata[3:2])) else $error("limit not written");
  a_unlock_key: assert property ($rose(prot_unlocked) |->
    $past(req.wr && req.addr == dcp_pkg::ADDR_KEY && req.wdata == 8'h12))
    else $error("unlock without last key byte");
  a_apply_lock: assert property (apply_pulse |-> !prot_unlocked &&
    $past(req.wr && req.addr == dcp_pkg::ADDR_KEY && req.wdata == 8'hCA))
    else $error("apply without lock key");
  a_cfg_hold: assert property (!apply_pulse |-> $stable(applied_cfg))
    else $error("applied values changed without lock");
  a_lp_wait: assert property ($rose(lp_enter) |-> $past(lp_request, LP_MIN))
    else $error("low power entry too early");
  a_lp_drop: assert property (!lp_request |=> !lp_enter)
    else $error("low power entry held without request");
  a_wake_gate: assert property (wake_tick |-> $past(low_power_state))
    else $error("wake tick outside low power");
  a_rel_wait: assert property ($rose(reset_release) |->
    $past(reset_release_req, REL_MIN)) else $error("reset released too early");
endmodule // dcp_regbank_checker

bind dcp_regbank dcp_regbank_checker #(.CYC_PER_US(CYC_PER_US)) dcp_regbank_checker_inst (
  .clk, .reset_n, .ce, .req, .rvalid, .sleep_state, .load_watch_active, .load_current_limit,
  .lp_request, .lp_enter, .low_power_state, .wake_tick, .reset_release_req, .reset_release,
  .prot_unlocked, .apply_pulse, .applied_cfg);

/* File: tb/dcp_host_model.sv */
// Host controller model: byte reads and writes and four-byte key sequences.
// Assumes tasks are entered just after a rising clock edge.
`timescale 1ns/1ps
module dcp_host_model (
  input  wire logic        clk,
  input  wire logic        rvalid,
  input  wire logic [7:0]  rdata,
  output dcp_pkg::dcp_req_t req
);
  initial req = '0;
  // Released lines show the inverse, so a stale address is never reused; an idle edge
  // follows each transfer so the request is never driven twice in one time step
  task automatic put(input logic w, input logic [5:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk);
    #1 req = '{wr: 1'h0, rd: 1'h0, addr: ~a, wdata: ~d};
    q = rvalid ? rdata : 8'hXX;
    @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    put(1'h1, a, d, q);
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    put(1'h0, a, 8'h00, d);
  endtask
  // Key bytes go one after another with no other write between them
  task automatic key(input logic [3:0][7:0] k);
    for (int i = 0; i < 4; i++) wr(dcp_pkg::ADDR_KEY, k[i]);
  endtask
endmodule // dcp_host_model

/* File: tb/dcp_regbank_tb_top.sv */
// Self-checking bench for the configuration and key register bank.
// Assumes timers scaled to one cycle per microsecond.
`timescale 1ns/1ps
module dcp_regbank_tb_top;
  typedef struct packed {logic w; logic [5:0] a; logic [7:0] d; logic [7:0] e;} dcp_row_t;
  localparam dcp_row_t ROWS [16] = '{
    '{1'h0, 6'h00, 8'h00, 8'h08}, '{1'h0, 6'h01, 8'h00, 8'h06}, '{1'h0, 6'h02, 8'h00, 8'h00},
    '{1'h0, 6'h03, 8'h00, 8'h00}, '{1'h0, 6'h04, 8'h00, 8'h01}, '{1'h0, 6'h0A, 8'h00, 8'h0B},
    '{1'h0, 6'h0B, 8'h00, 8'h01}, '{1'h0, 6'h28, 8'h00, 8'h01}, '{1'h0, 6'h3F, 8'h00, 8'h00},
    '{1'h1, 6'h00, 8'hFF, 8'hCF}, '{1'h1, 6'h01, 8'hFF, 8'h07}, '{1'h1, 6'h02, 8'hFF, 8'h1F},
    '{1'h1, 6'h04, 8'h55, 8'h01}, '{1'h1, 6'h0B, 8'h33, 8'h01}, '{1'h1, 6'h03, 8'h77, 8'h77},
    '{1'h1, 6'h3F, 8'h77, 8'h00}};
  logic clk, reset_n, ce, rvalid, ext_core_supply_in, boost_on_in, buck_freq_in;
  logic low_power_state, sleep_state, lp_request, lp_enter, reset_release_req, reset_release;
  logic sync_src, sync_out, wake_tick, load_watch_active, prot_unlocked, apply_pulse;
  logic [1:0] load_current_limit;
  logic [7:0] rdata, d;
  dcp_pkg::dcp_req_t req;
  dcp_pkg::dcp_cfg_t applied_cfg;
  int n_errors = 0, cmp_count = 0, cyc = 0, n, n_apply = 0;
  dcp_regbank #(.CYC_PER_US(1)) dcp_regbank_inst (.clk, .reset_n, .ce, .req, .rdata, .rvalid,
    .ext_core_supply_in, .boost_on_in, .buck_freq_in, .low_power_state, .sleep_state,
    .lp_request, .lp_enter, .reset_release_req, .reset_release, .sync_src, .sync_out,
    .wake_tick, .load_watch_active, .load_current_limit, .prot_unlocked, .apply_pulse,
    .applied_cfg);
  dcp_host_model dcp_host_model_inst (.clk, .rvalid, .rdata, .req);
  ////////////////////////////////////////////////////////////////
  always #4 clk = ~clk;
  // Lock pulses counted mid-cycle, where the registered pulse is settled
  always @(negedge clk) begin
    if (apply_pulse === 1'h1) n_apply++;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  // Counts cycles until sig rises, bounded so a dead timer cannot hang the run
  task automatic wait_rise(ref logic sig);
    n = 0;
    while (sig !== 1'h1 && n < 3000) begin
      @(posedge clk);
      #1 n++;
    end
  endtask
  task automatic print_verdict();
    if (n_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    {clk, reset_n, ext_core_supply_in, boost_on_in, buck_freq_in, low_power_state} = '0;
    {sleep_state, lp_request, reset_release_req, sync_src} = '0;
    ce = 1'h1;
    repeat (5) @(posedge clk);
    #1 reset_n = 1'h1;
    foreach (ROWS[i]) begin
      if (ROWS[i].w) dcp_host_model_inst.wr(ROWS[i].a, ROWS[i].d);
      dcp_host_model_inst.rd(ROWS[i].a, d);
      chk($sformatf("row %0d", i), ROWS[i].e, d);
    end
    {ext_core_supply_in, buck_freq_in} = 2'h3;
    @(posedge clk);
    #1 dcp_host_model_inst.rd(6'h02, d);
    chk("status", 8'hBF, d);
    {ext_core_supply_in, boost_on_in, buck_freq_in} = 3'h2;
    @(posedge clk);
    #1 dcp_host_model_inst.rd(6'h02, d);
    chk("status boost", 8'h5F, d);
    dcp_host_model_inst.wr(6'h02, 8'h03);
    chk("sync shifted", 8'h01, sync_out);
    sync_src = 1'h1;
    dcp_host_model_inst.wr(6'h02, 8'h1D);
    chk("sync plain", 8'h01, sync_out);
    chk("watch", 8'h01, load_watch_active);
    chk("limit", 8'h03, load_current_limit);
    dcp_host_model_inst.wr(6'h02, 8'h00);
    chk("sync off", 8'h00, sync_out);
    sleep_state = 1'h1;
    @(posedge clk);
    #1 chk("watch sleep", 8'h01, load_watch_active);
    sleep_state = 1'h0;
    dcp_host_model_inst.key({8'h00, 8'h56, 8'hEF, 8'hAB});
    chk("broken key", 8'h00, prot_unlocked);
    dcp_host_model_inst.key({8'h12, 8'h56, 8'hEF, 8'hAB});
    chk("unlocked", 8'h01, prot_unlocked);
    for (int i = 0; i < 7; i++) dcp_host_model_inst.wr(6'h04 + 6'(i), 8'h10 + 8'(i));
    dcp_host_model_inst.rd(6'h0A, d);
    chk("request", 8'h16, d);
    dcp_host_model_inst.rd(6'h0B, d);
    chk("mirror before lock", 8'h01, d);
    dcp_host_model_inst.key({8'hCA, 8'hBE, 8'h34, 8'hDF});
    chk("apply", 8'h01, 8'(n_apply));
    chk("locked", 8'h00, prot_unlocked);
    chk("applied", 8'h16, applied_cfg.val[6]);
    dcp_host_model_inst.wr(6'h04, 8'h99);
    dcp_host_model_inst.rd(6'h04, d);
    chk("locked write", 8'h10, d);
    // A write while the clock enable is low must leave the register untouched
    ce = 1'h0;
    dcp_host_model_inst.wr(6'h00, 8'h00);
    ce = 1'h1;
    dcp_host_model_inst.rd(6'h00, d);
    chk("frozen", 8'hCF, d);
    for (int i = 0; i < 2; i++) begin
      n = i ? 15 : 0;
      dcp_host_model_inst.wr(6'h00, 8'h80 | 8'(n));
      d = 8'(n);
      lp_request = 1'h1;
      wait_rise(lp_enter);
      chk("entry wait", 8'h01, 8'(n >= (d + 1) * 100 && n <= (d + 1) * 100 + 2));
      lp_request = 1'h0;
      @(posedge clk);
      #1 chk("entry drop", 8'h00, lp_enter);
    end
    low_power_state = 1'h1;
    wait_rise(wake_tick);
    @(posedge clk);
    #1 wait_rise(wake_tick);
    chk("tick period", 8'h09, 8'(n));
    dcp_host_model_inst.wr(6'h00, 8'hC0);
    wait_rise(wake_tick);
    chk("tick slow", 8'h01, 8'(n == 3000));
    dcp_host_model_inst.wr(6'h00, 8'h00);
    wait_rise(wake_tick);
    chk("tick off", 8'h01, 8'(n == 3000));
    low_power_state = 1'h0;
    dcp_host_model_inst.wr(6'h01, 8'h00);
    reset_release_req = 1'h1;
    wait_rise(reset_release);
    chk("release wait", 8'h01, 8'(n >= 200 && n <= 202));
    reset_n = 1'h0;
    repeat (2) @(posedge clk);
    #1 reset_n = 1'h1;
    dcp_host_model_inst.rd(6'h0B, d);
    chk("mirror reset", 8'h01, d);
    dcp_host_model_inst.rd(6'h03, d);
    chk("key reset", 8'h00, d);
    print_verdict();
  end
endmodule // dcp_regbank_tb_top
